// [sfs_status_regs.sv]
// Purpose: status register bank of a serial flash device
// Assumes: a command decoder delivers one-cycle command strobes
// Notes: reset is treated as power-up; the first status register's volatile bits load from the
// non-volatile byte in the first cycle after reset is released
`timescale 1ns/100ps
`default_nettype none

module sfs_status_regs #(
	parameter int unsigned NV_WRITE_CYCLES = sfs_pkg::NV_WRITE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic write_protect_n,
	input wire logic bp_volatile_mode,
	input wire logic write_latch_set_cmd,
	input wire logic write_latch_clear_cmd,
	input wire sfs_pkg::sfs_wr_t register_write_cmd,
	input wire logic program_cmd,
	input wire logic erase_cmd,
	input wire logic clear_error_cmd,
	input wire sfs_pkg::sfs_engine_t engine,
	input wire logic [1:0] rd_sel,
	output logic [7:0] rd_data_q,
	output logic [2:0] protect_bits_q,
	output logic write_enable_latch_q,
	output logic busy_flag_q,
	output logic program_go_q,
	output logic erase_go_q,
	output logic config_write_go_q,
	output logic write_refused_q,
	output logic config_write_locked_q
);

	localparam int unsigned TW = $clog2(NV_WRITE_CYCLES + 1);
	localparam logic [TW-1:0] T_LOAD = TW'(NV_WRITE_CYCLES - 1);
	localparam logic [TW-1:0] T_ZERO = '0;
	localparam logic [TW-1:0] T_ONE = TW'(1);

	sfs_pkg::sfs_state_t state_q;
	sfs_pkg::sfs_state_t state_d;
	logic [TW-1:0] timer_q;
	logic [7:0] pend_data_q;
	logic perr_q;
	logic eerr_q;
	logic [2:0] bp_q;
	logic erase_eval_result_q;
	logic es_q;
	logic ps_q;
	logic [7:0] nv_byte;
	logic [7:0] status_one_volatile;
	logic [7:0] status_two_volatile;
	logic nv_prog;
	logic [7:0] nv_prog_mask;
	logic [7:0] nv_force_mask;
	logic [7:0] nv_force_val;
	logic lock_active;
	logic idle;
	logic gate_open;
	logic wr_hits_locked;
	logic wr_accept;
	logic nv_write_start;

	// protection field of a status byte, shared by copy, write and guard paths
	function automatic logic [2:0] bp_field(input logic [7:0] b);
		return b[sfs_pkg::SR1_BP_HI:sfs_pkg::SR1_BP_LO];
	endfunction

	// does a write command aim at the given register select code
	function automatic logic targets(input sfs_pkg::sfs_wr_t w, input logic [1:0] sel);
		return w.target == sel;
	endfunction

	// stored lock bit only matters while the protect pin is held low
	assign lock_active = nv_byte[sfs_pkg::SR1_LOCK_BIT] & ~write_protect_n;
	assign idle = (state_q == sfs_pkg::SFS_ST_IDLE);
	// no write of any kind while busy or without the latch
	assign gate_open = write_enable_latch_q & ~busy_flag_q & idle;

	// every write target is a status or first config register
	assign wr_hits_locked = lock_active;
	assign wr_accept = register_write_cmd.strobe & gate_open & ~wr_hits_locked;
	assign nv_write_start = wr_accept & targets(register_write_cmd, sfs_pkg::SEL_STATUS_ONE_NONVOLATILE);

	// commit of the pending byte happens on the last cycle of the write time
	assign nv_prog = (state_q == sfs_pkg::SFS_ST_NVWR) & (timer_q == T_ZERO);

	// in volatile mode the stored protection bits are frozen at 111b
	always_comb begin
		nv_prog_mask = sfs_pkg::STATUS_ONE_NONVOLATILE_USER_MASK;
		nv_force_mask = 8'h00;
		nv_force_val = 8'h00;
		if (bp_volatile_mode) begin
			nv_prog_mask = sfs_pkg::STATUS_ONE_NONVOLATILE_USER_MASK & ~sfs_pkg::STATUS_ONE_NONVOLATILE_BP_MASK;
			nv_force_mask = sfs_pkg::STATUS_ONE_NONVOLATILE_BP_MASK;
			nv_force_val[sfs_pkg::SR1_BP_HI:sfs_pkg::SR1_BP_LO] = sfs_pkg::BP_FORCED;
		end
	end

	// read-only default bits sit outside the user mask of the cell
	sfs_nv_cell #(
		.WIDTH(sfs_pkg::REG_W),
		.RESET_VAL(sfs_pkg::STATUS_ONE_NONVOLATILE_RESET),
		.USER_MASK(sfs_pkg::STATUS_ONE_NONVOLATILE_USER_MASK)
	) u_nv (
		.core_clk(core_clk),
		.rst(rst),
		.prog_en(nv_prog),
		.prog_data(pend_data_q),
		.prog_mask(nv_prog_mask),
		.force_mask(nv_force_mask),
		.force_val(nv_force_val),
		.stored_q(nv_byte)
	);

	// first volatile register view; lock bit is a live mirror
	always_comb begin
		status_one_volatile = 8'h00;
		status_one_volatile[sfs_pkg::SR1_LOCK_BIT] = nv_byte[sfs_pkg::SR1_LOCK_BIT];
		status_one_volatile[sfs_pkg::SR1_PERR_BIT] = perr_q;
		status_one_volatile[sfs_pkg::SR1_EERR_BIT] = eerr_q;
		status_one_volatile[sfs_pkg::SR1_BP_HI:sfs_pkg::SR1_BP_LO] = bp_q;
		status_one_volatile[sfs_pkg::SR1_WEL_BIT] = write_enable_latch_q;
		status_one_volatile[sfs_pkg::SR1_BUSY_BIT] = busy_flag_q;
	end

	// second volatile register; reserved bits stay zero
	always_comb begin
		status_two_volatile = sfs_pkg::STATUS_TWO_VOLATILE_RESET;
		status_two_volatile[sfs_pkg::SR2_ERASE_EVAL_RESULT_BIT] = erase_eval_result_q;
		status_two_volatile[sfs_pkg::SR2_ES_BIT] = es_q;
		status_two_volatile[sfs_pkg::SR2_PS_BIT] = ps_q;
	end

	sfs_rd_port u_rd (
		.core_clk(core_clk),
		.rst(rst),
		.rd_sel(rd_sel),
		.status_one_nonvolatile(nv_byte),
		.status_one_volatile(status_one_volatile),
		.status_two_volatile(status_two_volatile),
		.rd_data_q(rd_data_q)
	);

	// sequencer: power-up load, idle, non-volatile commit
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sfs_pkg::SFS_ST_LOAD: begin
				state_d = sfs_pkg::SFS_ST_IDLE;
			end
			sfs_pkg::SFS_ST_IDLE: begin
				if (nv_write_start) begin
					state_d = sfs_pkg::SFS_ST_NVWR;
				end
			end
			sfs_pkg::SFS_ST_NVWR: begin
				if (timer_q == T_ZERO) begin
					state_d = sfs_pkg::SFS_ST_IDLE;
				end
			end
			default: begin
				state_d = sfs_pkg::SFS_ST_LOAD;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= sfs_pkg::SFS_ST_LOAD;
		end else begin
			state_q <= state_d;
		end
	end

	// commit timer and the byte waiting to be stored
	always_ff @(posedge core_clk) begin
		if (rst) begin
			timer_q <= T_ZERO;
			pend_data_q <= sfs_pkg::STATUS_ONE_NONVOLATILE_RESET;
		end else if (nv_write_start) begin
			timer_q <= T_LOAD;
			pend_data_q <= register_write_cmd.data;
		end else if (timer_q != T_ZERO) begin
			timer_q <= timer_q - T_ONE;
		end
	end

	// busy while committing or while the engine runs an operation
	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy_flag_q <= sfs_pkg::STATUS_ONE_NONVOLATILE_RESET[sfs_pkg::SR1_BUSY_BIT];
		end else if (state_q == sfs_pkg::SFS_ST_LOAD) begin
			busy_flag_q <= nv_byte[sfs_pkg::SR1_BUSY_BIT];
		end else begin
			busy_flag_q <= engine.busy | nv_write_start | (state_d == sfs_pkg::SFS_ST_NVWR);
		end
	end

	// latch moves only on its own two commands; set wins a tie
	always_ff @(posedge core_clk) begin
		if (rst) begin
			write_enable_latch_q <= sfs_pkg::STATUS_ONE_NONVOLATILE_RESET[sfs_pkg::SR1_WEL_BIT];
		end else if (state_q == sfs_pkg::SFS_ST_LOAD) begin
			write_enable_latch_q <= nv_byte[sfs_pkg::SR1_WEL_BIT];
		end else if (write_latch_set_cmd) begin
			write_enable_latch_q <= 1'b1;
		end else if (write_latch_clear_cmd) begin
			write_enable_latch_q <= 1'b0;
		end
	end

	// program error flag: seeded from its default, engine set beats a clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			perr_q <= sfs_pkg::STATUS_ONE_NONVOLATILE_RESET[sfs_pkg::SR1_PERR_BIT];
		end else if (state_q == sfs_pkg::SFS_ST_LOAD) begin
			perr_q <= nv_byte[sfs_pkg::SR1_PERR_BIT];
		end else begin
			perr_q <= engine.program_fail | (perr_q & ~clear_error_cmd);
		end
	end

	// erase error flag: same policy, so a failure is never lost to a clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			eerr_q <= sfs_pkg::STATUS_ONE_NONVOLATILE_RESET[sfs_pkg::SR1_EERR_BIT];
		end else if (state_q == sfs_pkg::SFS_ST_LOAD) begin
			eerr_q <= nv_byte[sfs_pkg::SR1_EERR_BIT];
		end else begin
			eerr_q <= engine.erase_fail | (eerr_q & ~clear_error_cmd);
		end
	end

	// volatile protection bits: copy in stored mode, host-written otherwise
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bp_q <= sfs_pkg::BP_RESET;
		end else if (state_q == sfs_pkg::SFS_ST_LOAD) begin
			bp_q <= bp_field(nv_byte);
		end else if (!bp_volatile_mode) begin
			bp_q <= bp_field(nv_byte);
		end else if (wr_accept && targets(register_write_cmd, sfs_pkg::SEL_STATUS_ONE_VOLATILE)) begin
			bp_q <= bp_field(register_write_cmd.data);
		end
	end

	// protection range handed to the array guard
	always_ff @(posedge core_clk) begin
		if (rst) begin
			protect_bits_q <= sfs_pkg::BP_RESET;
		end else if (bp_volatile_mode) begin
			protect_bits_q <= bp_q;
		end else begin
			protect_bits_q <= bp_field(nv_byte);
		end
	end

	// evaluation result holds until the next evaluation reports
	always_ff @(posedge core_clk) begin
		if (rst) begin
			erase_eval_result_q <= sfs_pkg::STATUS_TWO_VOLATILE_RESET[sfs_pkg::SR2_ERASE_EVAL_RESULT_BIT];
		end else if (engine.eval_done) begin
			erase_eval_result_q <= engine.eval_completed;
		end
	end

	// suspend flags follow the engine levels, one cycle late
	always_ff @(posedge core_clk) begin
		if (rst) begin
			es_q <= sfs_pkg::STATUS_TWO_VOLATILE_RESET[sfs_pkg::SR2_ES_BIT];
			ps_q <= sfs_pkg::STATUS_TWO_VOLATILE_RESET[sfs_pkg::SR2_PS_BIT];
		end else begin
			es_q <= engine.erase_suspended;
			ps_q <= engine.program_suspended;
		end
	end

	// program launch pulse toward the engine, gated by the latch
	always_ff @(posedge core_clk) begin
		if (rst) begin
			program_go_q <= 1'b0;
		end else begin
			program_go_q <= program_cmd & gate_open;
		end
	end

	// erase launch pulse; a program in the same cycle takes precedence
	always_ff @(posedge core_clk) begin
		if (rst) begin
			erase_go_q <= 1'b0;
		end else begin
			erase_go_q <= erase_cmd & gate_open & ~program_cmd;
		end
	end

	// config writes are only passed on, the config bank lives elsewhere
	always_ff @(posedge core_clk) begin
		if (rst) begin
			config_write_go_q <= 1'b0;
		end else begin
			config_write_go_q <= wr_accept & targets(register_write_cmd, sfs_pkg::SEL_CFG1);
		end
	end

	// one refusal pulse covers both the lock and the latch gate
	always_ff @(posedge core_clk) begin
		if (rst) begin
			write_refused_q <= 1'b0;
		end else begin
			write_refused_q <= register_write_cmd.strobe & ~wr_accept;
		end
	end

	// lock level for the config bank, which has no view of the pin
	always_ff @(posedge core_clk) begin
		if (rst) begin
			config_write_locked_q <= 1'b0;
		end else begin
			config_write_locked_q <= lock_active;
		end
	end

endmodule
`default_nettype wire

// [sfs_pkg.sv]
// Purpose: shared constants and types of the flash status register bank
// Assumes: one 100 MHz core clock, synchronous active-high reset
// Notes: bit positions follow the status register layouts
package sfs_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	// time a non-volatile status byte takes to commit
	localparam int unsigned NV_WRITE_TIME_NS = 200;
	localparam int unsigned NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned REG_W = 8;
	localparam int unsigned BP_W = 3;

	// first status register bit positions (both copies)
	localparam int unsigned SR1_LOCK_BIT = 7;
	localparam int unsigned SR1_PERR_BIT = 6;
	localparam int unsigned SR1_EERR_BIT = 5;
	localparam int unsigned SR1_BP_HI = 4;
	localparam int unsigned SR1_BP_LO = 2;
	localparam int unsigned SR1_WEL_BIT = 1;
	localparam int unsigned SR1_BUSY_BIT = 0;

	// second status register bit positions
	localparam int unsigned SR2_ERASE_EVAL_RESULT_BIT = 2;
	localparam int unsigned SR2_ES_BIT = 1;
	localparam int unsigned SR2_PS_BIT = 0;

	localparam logic [7:0] STATUS_ONE_NONVOLATILE_RESET = 8'h00;
	localparam logic [7:0] STATUS_TWO_VOLATILE_RESET = 8'h00;
	localparam logic [7:0] STATUS_ONE_NONVOLATILE_USER_MASK = 8'h9C;
	localparam logic [7:0] STATUS_ONE_NONVOLATILE_BP_MASK = 8'h1C;
	localparam logic [7:0] STATUS_ONE_VOLATILE_BP_MASK = 8'h1C;
	localparam logic [7:0] READ_NONE = 8'h00;
	localparam logic [2:0] BP_FORCED = 3'h7;
	localparam logic [2:0] BP_RESET = 3'h0;

	// register select codes for write target and read select
	localparam logic [1:0] SEL_STATUS_ONE_NONVOLATILE = 2'h0;
	localparam logic [1:0] SEL_STATUS_ONE_VOLATILE = 2'h1;
	localparam logic [1:0] SEL_STATUS_TWO_VOLATILE = 2'h2;
	localparam logic [1:0] SEL_CFG1 = 2'h3;

	typedef enum logic [2:0] {
		SFS_ST_LOAD = 3'h1,
		SFS_ST_IDLE = 3'h2,
		SFS_ST_NVWR = 3'h4
	} sfs_state_t;

	// register write command as delivered by the command decoder
	typedef struct packed {
		logic strobe;
		logic [1:0] target;
		logic [7:0] data;
	} sfs_wr_t;

	// status coming back from the embedded program/erase engine
	typedef struct packed {
		logic busy;
		logic program_fail;
		logic erase_fail;
		logic erase_suspended;
		logic program_suspended;
		logic eval_done;
		logic eval_completed;
	} sfs_engine_t;

endpackage

// [sfs_nv_cell.sv]
// Purpose: one non-volatile status byte with user and forced bits
// Assumes: reset stands for a power cycle, restoring the stored default
// Notes: forced bits override any user program in the same cycle
`timescale 1ns/100ps
`default_nettype none
module sfs_nv_cell #(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0,
	parameter logic [WIDTH-1:0] USER_MASK = '1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic prog_en,
	input wire logic [WIDTH-1:0] prog_data,
	input wire logic [WIDTH-1:0] prog_mask,
	input wire logic [WIDTH-1:0] force_mask,
	input wire logic [WIDTH-1:0] force_val,
	output logic [WIDTH-1:0] stored_q
);

	logic [WIDTH-1:0] stored_d;
	logic [WIDTH-1:0] write_mask;

	// read-only default bits never take user data
	always_comb begin
		write_mask = prog_mask & USER_MASK;
		stored_d = stored_q;
		if (prog_en) begin
			stored_d = (stored_q & ~write_mask) | (prog_data & write_mask);
		end
		stored_d = (stored_d & ~force_mask) | (force_val & force_mask);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stored_q <= RESET_VAL;
		end else begin
			stored_q <= stored_d;
		end
	end

endmodule
`default_nettype wire

// [sfs_rd_port.sv]
// Purpose: registered read-out of the selected status register
// Assumes: select is steady for the cycle it is sampled
// Notes: the unused select code reads as zero
`timescale 1ns/100ps
`default_nettype none
module sfs_rd_port (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] rd_sel,
	input wire logic [7:0] status_one_nonvolatile,
	input wire logic [7:0] status_one_volatile,
	input wire logic [7:0] status_two_volatile,
	output logic [7:0] rd_data_q
);

	// one cycle of latency buys a flop-driven output
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data_q <= sfs_pkg::READ_NONE;
		end else begin
			unique case (rd_sel)
				sfs_pkg::SEL_STATUS_ONE_NONVOLATILE: rd_data_q <= status_one_nonvolatile;
				sfs_pkg::SEL_STATUS_ONE_VOLATILE: rd_data_q <= status_one_volatile;
				sfs_pkg::SEL_STATUS_TWO_VOLATILE: rd_data_q <= status_two_volatile;
				default: rd_data_q <= sfs_pkg::READ_NONE;
			endcase
		end
	end

endmodule
`default_nettype wire

// [sfs_status_props.sv]
// Purpose: port checks of the flash status register bank
// Assumes: one clock, synchronous active-high reset
// Notes: no command is issued in the load cycle after reset
`timescale 1ns/100ps
`default_nettype none
module sfs_status_props #(
	parameter int unsigned NV_WRITE_CYCLES = 20
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic write_latch_set_cmd,
	input wire logic write_latch_clear_cmd,
	input wire sfs_pkg::sfs_wr_t register_write_cmd,
	input wire logic program_cmd,
	input wire sfs_pkg::sfs_engine_t engine,
	input wire logic [1:0] rd_sel,
	input wire logic [7:0] rd_data_q,
	input wire logic write_enable_latch_q,
	input wire logic busy_flag_q,
	input wire logic program_go_q,
	input wire logic write_refused_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// latch follows only its own two commands
	a_latch_set: assert property (write_latch_set_cmd |=> write_enable_latch_q) else $error("latch not set");
	a_latch_clear: assert property (
		write_latch_clear_cmd && !write_latch_set_cmd |=> !write_enable_latch_q)
		else $error("latch not cleared");
	a_latch_holds: assert property (
		!write_latch_set_cmd && !write_latch_clear_cmd |=> $stable(write_enable_latch_q))
		else $error("latch moved");
	// gating of program and register writes, busy from the engine, reserved read bits
	a_program_gated: assert property (
		program_go_q |-> $past(program_cmd) && $past(write_enable_latch_q) && !$past(busy_flag_q))
		else $error("program go ungated");
	a_refuse_unlatched: assert property (
		register_write_cmd.strobe && !write_enable_latch_q |=> write_refused_q)
		else $error("write not refused");
	a_refuse_busy: assert property (
		register_write_cmd.strobe && busy_flag_q |=> write_refused_q)
		else $error("busy write not refused");
	a_busy_engine: assert property (engine.busy |=> busy_flag_q) else $error("busy missing");
	a_sr2_reserved: assert property (
		rd_sel == sfs_pkg::SEL_STATUS_TWO_VOLATILE |=> rd_data_q[7:3] == 5'h00)
		else $error("reserved bits set");
endmodule
bind sfs_status_regs sfs_status_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_props (.core_clk, .rst,
	.write_latch_set_cmd, .write_latch_clear_cmd, .register_write_cmd, .program_cmd, .engine, .rd_sel,
	.rd_data_q, .write_enable_latch_q, .busy_flag_q, .program_go_q, .write_refused_q);
`default_nettype wire

// [sfs_host.sv]
// Purpose: host controller model issuing status commands
// Assumes: commands change on the falling edge of core_clk
// Notes: each command ends with a gap cycle
`timescale 1ns/100ps
`default_nettype none
module sfs_host (
	input wire logic core_clk,
	input wire logic busy_flag_q,
	input wire logic [7:0] rd_data_q,
	input wire logic config_write_go_q,
	input wire logic write_refused_q,
	output logic [4:0] pulse_q,
	output sfs_pkg::sfs_wr_t wr_q,
	output logic [1:0] sel_q
);
	initial begin
		pulse_q = 5'h00;
		wr_q = '0;
		sel_q = 2'h0;
	end
	// one-cycle strobe: set, clear, program, erase, clear errors
	task automatic pulse(input int k);
		@(negedge core_clk);
		pulse_q[k] = 1'b1;
		@(negedge core_clk);
		pulse_q = 5'h00;
	endtask
	// answer sampled while the strobe is dropped; stale data inverted
	task automatic wr(input logic [1:0] t, input logic [7:0] v, output logic go, output logic rf);
		@(negedge core_clk);
		wr_q = {1'b1, t, v};
		@(negedge core_clk);
		go = config_write_go_q;
		rf = write_refused_q;
		wr_q = {1'b0, t, ~v};
	endtask
	task automatic rd(input logic [1:0] s, output logic [7:0] v);
		@(negedge core_clk);
		sel_q = s;
		@(negedge core_clk);
		v = rd_data_q;
	endtask
	// bounded wait so a stuck busy cannot hang the host
	task automatic idle();
		for (int i = 0; i < 200 && busy_flag_q !== 1'b0; i++)
			@(negedge core_clk);
	endtask
endmodule
`default_nettype wire

// [test_serial_flash_status_registers.sv]
// Purpose: self-checking bench of the flash status register bank
// Assumes: host model drives commands, bench drives pins and engine
// Notes: short commit count keeps the run brief
`timescale 1ns/100ps
`default_nettype none
module test_serial_flash_status_registers;
	localparam int unsigned NVC = 4;
	// sequence needs under 2000 cycles
	localparam int unsigned WATCH_NS = 40000;
	logic core_clk, rst, write_protect_n, bp_volatile_mode, go, rf;
	logic [4:0] pl;
	logic [1:0] rd_sel;
	logic [7:0] rd_data_q, d;
	logic [2:0] protect_bits_q;
	logic write_enable_latch_q, busy_flag_q, program_go_q, erase_go_q, config_write_go_q, write_refused_q;
	logic config_write_locked_q;
	sfs_pkg::sfs_wr_t register_write_cmd;
	sfs_pkg::sfs_engine_t engine;
	int num_errors = 0;
	int checked = 0;
	int m_nv, m_vbp, m_wel, m_err, n_go, m_est;
	sfs_status_regs #(.NV_WRITE_CYCLES(NVC)) uut (.core_clk, .rst, .write_protect_n, .bp_volatile_mode,
		.write_latch_set_cmd(pl[0]), .write_latch_clear_cmd(pl[1]), .register_write_cmd, .program_cmd(pl[2]),
		.erase_cmd(pl[3]), .clear_error_cmd(pl[4]), .engine, .rd_sel, .rd_data_q, .protect_bits_q,
		.write_enable_latch_q, .busy_flag_q, .program_go_q, .erase_go_q, .config_write_go_q, .write_refused_q,
		.config_write_locked_q);
	sfs_host host (.core_clk, .busy_flag_q, .rd_data_q, .config_write_go_q, .write_refused_q, .pulse_q(pl),
		.wr_q(register_write_cmd), .sel_q(rd_sel));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// go pulses last one cycle, so each counts once
	always @(posedge core_clk) begin
		if (!rst) begin
			n_go += program_go_q + erase_go_q;
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [7:0] sr1();
		return {m_nv[7], m_err[1:0], bp_volatile_mode ? m_vbp[2:0] : m_nv[4:2], m_wel[0], 1'b0};
	endfunction
	task automatic rdc(input logic [1:0] s, input logic [7:0] e, input string n);
		host.rd(s, d);
		chk(n, e, d);
	endtask
	// stored-byte write; acceptance decided by the model
	task automatic nvw(input logic [7:0] v);
		logic acc;
		acc = m_wel[0] && !(m_nv[7] && !write_protect_n);
		host.wr(2'h0, v, go, rf);
		chk("refused", {7'h00, !acc}, {7'h00, rf});
		chk("busy", {7'h00, acc}, {7'h00, busy_flag_q});
		if (acc) begin
			host.wr(2'h1, 8'h00, go, rf);
			chk("busy refusal", 8'h01, {7'h00, rf});
			m_nv = bp_volatile_mode ? (v & 8'h80) | 8'h1C : v & 8'h9C;
		end
		host.idle();
	endtask
	task automatic summarize();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#(WATCH_NS);
		num_errors++;
		summarize();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		write_protect_n = 1'b1;
		bp_volatile_mode = 1'b0;
		engine = '0;
		void'($urandom(23196));
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		repeat (3) @(negedge core_clk);
		rdc(2'h0, 8'h00, "status_one_nonvolatile");
		rdc(2'h1, 8'h00, "status_one_volatile");
		rdc(2'h2, 8'h00, "status_two_volatile");
		$display("done reset");
		host.pulse(2);
		host.pulse(3);
		nvw(8'h9C);
		chk("go count", 8'h00, 8'(n_go));
		rdc(2'h0, 8'(m_nv), "status_one_nonvolatile");
		$display("done latch off");
		host.pulse(0);
		m_wel = 1;
		host.wr(2'h1, 8'hE1, go, rf);
		rdc(2'h1, sr1(), "status_one_volatile latch");
		host.pulse(1);
		m_wel = 0;
		rdc(2'h1, sr1(), "status_one_volatile cleared");
		host.pulse(0);
		m_wel = 1;
		$display("done latch");
		repeat (4) begin
			nvw(8'($urandom));
			rdc(2'h0, 8'(m_nv), "status_one_nonvolatile");
			rdc(2'h1, sr1(), "status_one_volatile");
			chk("protect", 8'(m_nv[4:2]), {5'h00, protect_bits_q});
		end
		nvw(8'h80);
		write_protect_n = 1'b0;
		nvw(8'h1C);
		host.wr(2'h3, 8'h00, go, rf);
		chk("config locked", 8'h00, {7'h00, go});
		chk("config lock flag", {7'h00, m_nv[7] && !write_protect_n}, {7'h00, config_write_locked_q});
		write_protect_n = 1'b1;
		host.wr(2'h3, 8'h00, go, rf);
		chk("config go", 8'h01, {7'h00, go});
		chk("config lock flag", {7'h00, m_nv[7] && !write_protect_n}, {7'h00, config_write_locked_q});
		rdc(2'h0, 8'(m_nv), "status_one_nonvolatile lock");
		$display("done lock");
		nvw(8'h00);
		bp_volatile_mode = 1'b1;
		nvw(8'h00);
		rdc(2'h0, 8'(m_nv), "status_one_nonvolatile forced");
		d = 8'($urandom);
		m_vbp = d[4:2];
		host.wr(2'h1, d, go, rf);
		rdc(2'h1, sr1(), "status_one_volatile volatile");
		chk("protect", 8'(m_vbp), {5'h00, protect_bits_q});
		$display("done volatile");
		engine.busy = 1'b1;
		host.pulse(2);
		rdc(2'h1, sr1() | 8'h01, "status_one_volatile busy");
		engine.busy = 1'b0;
		host.idle();
		host.pulse(2);
		host.pulse(3);
		@(negedge core_clk);
		chk("go count", 8'h02, 8'(n_go));
		engine.program_fail = 1'b1;
		@(negedge core_clk);
		engine.program_fail = 1'b0;
		engine.erase_fail = 1'b1;
		@(negedge core_clk);
		engine.erase_fail = 1'b0;
		m_err = 3;
		rdc(2'h1, sr1(), "status_one_volatile errors");
		host.pulse(4);
		m_err = 0;
		rdc(2'h1, sr1(), "status_one_volatile no errors");
		// random engine levels; the first pass always reports an evaluation
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			engine.erase_suspended = d[1];
			engine.program_suspended = d[0];
			engine.eval_completed = d[2];
			engine.eval_done = d[3] | (i == 0);
			if (engine.eval_done) begin
				m_est = d[2];
			end
			@(negedge core_clk);
			engine.eval_done = 1'b0;
			rdc(2'h2, {5'h00, m_est[0], d[1], d[0]}, "status_two_volatile");
		end
		$display("done engine");
		summarize();
	end
endmodule
`default_nettype wire
